// ### mrv_defines.vh
/*
 Constants shared by the request validator: exception codes, function codes,
 address windows, limits, timing counts and the Modbus frame layout.
 Assumes a 25 MHz clock and inclusion by bare name.
*/
`ifndef MRV_DEFINES_VH
`define MRV_DEFINES_VH

// ----------------------------------------
// Exception codes
// ----------------------------------------
`define MRV_EXC_NONE 8'h00
`define MRV_EXC_FUNC 8'h01
`define MRV_EXC_ADDR 8'h02
`define MRV_EXC_VALUE 8'h03
`define MRV_EXC_PATH 8'h0A
`define MRV_EXC_TARGET 8'h0B
`define MRV_EXC_FLAG 8'h80

// ----------------------------------------
// Function codes accepted
// ----------------------------------------
`define MRV_FC_READ_HOLD 8'h03
`define MRV_FC_READ_INPUT 8'h04
`define MRV_FC_WRITE_SINGLE 8'h06
`define MRV_FC_WRITE_MULTI 8'h10
`define MRV_FC_DEVICE_ID 8'h2B

// ----------------------------------------
// Register windows (one-based register numbers)
// ----------------------------------------
`define MRV_HOLD_LO 16'h9C41
`define MRV_HOLD_HI 16'hC15C
`define MRV_ANALOG_LO 16'h7531
`define MRV_ANALOG_HI 16'h7D00
`define MRV_INPUT_LO 16'h88B8
`define MRV_INPUT_HI 16'h8A6C
`define MRV_GWINFO_LO 16'h891C
`define MRV_GWINFO_HI 16'h8AAC

// ----------------------------------------
// Limits and frame layout
// ----------------------------------------
`define MRV_MAX_REGS 16'h0064
`define MRV_MAX_ANALOG 16'h000A
`define MRV_PROTO_ID 16'h0000
`define MRV_EXC_LEN 16'h0003
`define MRV_TIMEOUT_MS 32'h000003E8
`define MRV_CLK_KHZ 32'h000061A8
`define MRV_TIMEOUT_CYC (`MRV_TIMEOUT_MS * `MRV_CLK_KHZ)

`endif

// ### mrv_range_check.v
/*
 Classifies a requested register span against the fire panel address windows.
 Purely combinational; the caller registers the results.
*/
`timescale 1ns/1ns
`include "mrv_defines.vh"
module mrv_range_check
(
   input wire [15:0] start_in,  // First register number
   input wire [15:0] count_in,  // Number of registers
   input wire is_input_in,      // Input-register read
   input wire is_gateway_in,    // Target unit is the gateway
   output reg legal_out,        // Span inside a supported window
   output reg analog_out        // Span inside the analog window
);

   reg [16:0] last;

   function in_win;
      input [16:0] lo_a;
      input [16:0] hi_a;
      input [16:0] a;
      input [16:0] b;
      begin
         in_win = (a >= lo_a) && (b <= hi_a);
      end
   endfunction

   always @*
   begin
      last = {1'b0, start_in} + {1'b0, count_in} - 17'h00001;
      analog_out = is_input_in &&
         in_win({1'b0, `MRV_ANALOG_LO}, {1'b0, `MRV_ANALOG_HI}, {1'b0, start_in}, last);
      if (is_input_in)
      begin
         // Gateway info window belongs to the gateway unit only
         legal_out = analog_out ||
            (!is_gateway_in && in_win({1'b0, `MRV_INPUT_LO}, {1'b0, `MRV_INPUT_HI},
               {1'b0, start_in}, last)) ||
            (is_gateway_in && in_win({1'b0, `MRV_GWINFO_LO}, {1'b0, `MRV_GWINFO_HI},
               {1'b0, start_in}, last));
      end
      else
      begin
         legal_out = in_win({1'b0, `MRV_HOLD_LO}, {1'b0, `MRV_HOLD_HI},
            {1'b0, start_in}, last);
      end
   end

endmodule // mrv_range_check

// ### mrv_analog_cache.v
/*
 Tracks the single analog group being refreshed from the panel network.
 A read of a new group, or of the same group after the timeout, is an
 initialization read. Assumes one request at a time.
*/
`timescale 1ns/1ns
`include "mrv_defines.vh"
module mrv_analog_cache
#(
   parameter TIMEOUT_CYC = `MRV_TIMEOUT_CYC
)
(
   input wire clk_in,          // Clock
   input wire rst_in,          // Synchronous reset
   input wire ce_in,           // Clock enable
   input wire read_in,         // Accepted analog read pulse
   input wire [15:0] start_in, // Group start
   input wire [15:0] count_in, // Group size
   output reg init_out,        // Read now offered is an initialization
   output reg active_out       // Refresh routine running
);

   reg [31:0] timer;
   reg [15:0] grp_start;
   reg [15:0] grp_count;
   wire same;

   assign same = active_out && grp_start == start_in && grp_count == count_in;

   // Decided in the cycle of the read, so the reply of that very read knows
   // whether a different or expired group is being replaced
   always @*
   begin
      init_out = !same;
   end

   always @(posedge clk_in)
   begin
      if (rst_in)
      begin
         timer <= 32'h00000000;
         grp_start <= 16'h0000;
         grp_count <= 16'h0000;
         active_out <= 1'b0;
      end
      else if (ce_in)
      begin
         if (read_in)
         begin
            // Each read restarts the refresh window
            timer <= TIMEOUT_CYC;
            grp_start <= start_in;
            grp_count <= count_in;
            active_out <= 1'b1;
         end
         else if (active_out)
         begin
            if (timer == 32'h00000001)
            begin
               active_out <= 1'b0;
            end
            timer <= timer - 32'h00000001;
         end
      end
   end

endmodule // mrv_analog_cache

// ### mrv_request_validator.v
/*
 Modbus/TCP request validator. Takes a parsed request, checks it and either
 passes it on to the panel side or builds an exception reply header.
 Assumes the request fields are stable while req_valid_in is high and that
 the client sends one request at a time.
*/
`timescale 1ns/1ns
`include "mrv_defines.vh"
module mrv_request_validator
#(
   parameter TIMEOUT_CYC = `MRV_TIMEOUT_CYC
)
(
   input wire clk_in,               // 25 MHz clock
   input wire rst_in,               // Synchronous reset, high
   input wire ce_in,                // Clock enable
   input wire req_valid_in,         // Request pulse
   input wire [15:0] trans_id_in,   // Transaction identifier
   input wire [15:0] proto_id_in,   // Protocol identifier
   input wire [7:0] unit_id_in,     // Unit identifier
   input wire [7:0] func_in,        // Function code
   input wire [15:0] start_in,      // First register number
   input wire [15:0] count_in,      // Register count
   input wire write_ok_in,          // Write data valid for target
   input wire [7:0] gw_unit_in,     // Gateway unit identifier
   input wire unit_cfg_in,          // Unit configured for monitoring
   input wire panel_online_in,      // Addressed panel online
   input wire net_ok_in,            // Panel network healthy
   input wire func_ok_in,           // Panel supports function
   input wire present_in,           // All mapped points present
   input wire all_analog_in,        // All points are current-loop modules
   input wire threshold_in,         // Module crossed first threshold
   input wire [15:0] panel_value_in, // Value from panel
   output reg fwd_valid_out,        // Pass request to panel side
   output reg exc_valid_out,        // Exception reply ready
   output reg [15:0] exc_trans_out, // Echoed transaction id
   output reg [15:0] exc_proto_out, // Protocol id of reply
   output reg [15:0] exc_len_out,   // Length field
   output reg [7:0] exc_unit_out,   // Echoed unit id
   output reg [7:0] exc_func_out,   // Function with top bit set
   output reg [7:0] exc_code_out,   // Exception code
   output reg zero_fill_out,        // Analog reply returns zeros
   output reg [15:0] value_out,     // Analog value to report
   output reg refresh_out           // Analog refresh routine running
);

   // Refusal causes, listed in the order in which they win
   localparam CS_PROTO = 0;
   localparam CS_UNIT = 1;
   localparam CS_FUNC = 2;
   localparam CS_GW_CMD = 3;
   localparam CS_OFFLINE = 4;
   localparam CS_PANEL_FUNC = 5;
   localparam CS_MANY = 6;
   localparam CS_SPAN = 7;
   localparam CS_MIXED = 8;
   localparam CS_ANALOG_MANY = 9;
   localparam CS_ABSENT = 10;
   localparam CS_DATA = 11;
   localparam CS_COUNT = 12;

   reg [7:0] next_code;
   reg [CS_COUNT-1:0] cause;
   wire [CS_COUNT-1:0] first;
   wire [8*CS_COUNT-1:0] first_code;
   wire is_gw;
   wire is_input;
   wire legal;
   wire analog;
   wire init_rd;
   wire active;
   wire analog_rd;
   integer k;

   // ----------------------------------------
   // Function code decoding
   // ----------------------------------------
   function fc_is_read;
      input [7:0] fc;
      begin
         fc_is_read = (fc == `MRV_FC_READ_HOLD) || (fc == `MRV_FC_READ_INPUT);
      end
   endfunction

   function fc_is_input;
      input [7:0] fc;
      begin
         fc_is_input = fc == `MRV_FC_READ_INPUT;
      end
   endfunction

   function fc_is_write;
      input [7:0] fc;
      begin
         fc_is_write = (fc == `MRV_FC_WRITE_SINGLE) || (fc == `MRV_FC_WRITE_MULTI);
      end
   endfunction

   function fc_is_ident;
      input [7:0] fc;
      begin
         fc_is_ident = fc == `MRV_FC_DEVICE_ID;
      end
   endfunction

   // Anything outside this set is refused before any panel is asked
   function fc_known;
      input [7:0] fc;
      begin
         fc_known = fc_is_read(fc) || fc_is_write(fc) || fc_is_ident(fc);
      end
   endfunction

   // Exception code reported for each refusal cause
   function [7:0] cause_code;
      input integer idx;
      begin
         case (idx)
            CS_PROTO: cause_code = `MRV_EXC_FUNC;
            CS_UNIT: cause_code = `MRV_EXC_PATH;
            CS_FUNC: cause_code = `MRV_EXC_FUNC;
            CS_GW_CMD: cause_code = `MRV_EXC_FUNC;
            CS_OFFLINE: cause_code = `MRV_EXC_TARGET;
            CS_PANEL_FUNC: cause_code = `MRV_EXC_FUNC;
            CS_MANY: cause_code = `MRV_EXC_VALUE;
            CS_SPAN: cause_code = `MRV_EXC_ADDR;
            CS_MIXED: cause_code = `MRV_EXC_ADDR;
            CS_ANALOG_MANY: cause_code = `MRV_EXC_VALUE;
            CS_ABSENT: cause_code = `MRV_EXC_ADDR;
            CS_DATA: cause_code = `MRV_EXC_VALUE;
            default: cause_code = `MRV_EXC_NONE;
         endcase
      end
   endfunction

   assign is_gw = unit_id_in == gw_unit_in;
   assign is_input = fc_is_input(func_in);

   // ----------------------------------------
   // Address window checking
   // ----------------------------------------
   mrv_range_check u_mrv_range_check
   (
      .start_in(start_in),
      .count_in(count_in),
      .is_input_in(is_input),
      .is_gateway_in(is_gw),
      .legal_out(legal),
      .analog_out(analog)
   );

   // ----------------------------------------
   // Exception priority
   // ----------------------------------------
   always @*
   begin
      cause[CS_PROTO] = proto_id_in != `MRV_PROTO_ID;
      cause[CS_UNIT] = !is_gw && !unit_cfg_in;
      cause[CS_FUNC] = !fc_known(func_in);
      cause[CS_GW_CMD] = is_gw && fc_is_write(func_in);
      cause[CS_OFFLINE] = !is_gw && (!panel_online_in || !net_ok_in);
      cause[CS_PANEL_FUNC] = !is_gw && !func_ok_in;
      cause[CS_MANY] = fc_is_read(func_in) &&
         count_in > `MRV_MAX_REGS;
      cause[CS_SPAN] = !fc_is_ident(func_in) && !legal;
      cause[CS_MIXED] = analog && !all_analog_in;
      cause[CS_ANALOG_MANY] = analog && count_in > `MRV_MAX_ANALOG;
      cause[CS_ABSENT] = !is_gw && !fc_is_ident(func_in) && !present_in;
      cause[CS_DATA] = fc_is_write(func_in) && !write_ok_in;
   end

   // ----------------------------------------
   // Priority pick
   // ----------------------------------------
   // Only the highest ranked cause reaches the code, so a reply never
   // carries a mix of two codes
   genvar gi;
   generate
      for (gi = 0; gi < CS_COUNT; gi = gi + 1)
      begin : g_prio
         if (gi == 0)
         begin : g_top
            assign first[gi] = cause[gi];
         end
         else
         begin : g_rest
            assign first[gi] = cause[gi] && !(|cause[gi-1:0]);
         end
         assign first_code[8*gi +: 8] = first[gi] ? cause_code(gi) : `MRV_EXC_NONE;
      end
   endgenerate

   always @*
   begin
      next_code = `MRV_EXC_NONE;
      for (k = 0; k < CS_COUNT; k = k + 1)
      begin
         next_code = next_code | first_code[8*k +: 8];
      end
   end

   assign analog_rd = req_valid_in && ce_in && analog && next_code == `MRV_EXC_NONE;

   // ----------------------------------------
   // Analog refresh tracking
   // ----------------------------------------
   mrv_analog_cache #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_mrv_analog_cache
   (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .read_in(analog_rd),
      .start_in(start_in),
      .count_in(count_in),
      .init_out(init_rd),
      .active_out(active)
   );

   // ----------------------------------------
   // Reply registers
   // ----------------------------------------
   // Decision is registered so every output except refresh_out is one cycle after the request;
   // this keeps the reply far inside the one-second budget.
   always @(posedge clk_in)
   begin
      if (rst_in)
      begin
         fwd_valid_out <= 1'b0;
         exc_valid_out <= 1'b0;
         refresh_out <= 1'b0;
      end
      else if (ce_in)
      begin
         refresh_out <= active;
         // Exactly one answer per taken request, never one without
         fwd_valid_out <= req_valid_in && next_code == `MRV_EXC_NONE;
         exc_valid_out <= req_valid_in && next_code != `MRV_EXC_NONE;
      end
   end

   // Header fields hold until the next refusal
   always @(posedge clk_in)
   begin
      if (rst_in)
      begin
         exc_trans_out <= 16'h0000;
         exc_proto_out <= 16'h0000;
         exc_len_out <= 16'h0000;
         exc_unit_out <= 8'h00;
         exc_func_out <= 8'h00;
         exc_code_out <= 8'h00;
      end
      else if (ce_in && req_valid_in && next_code != `MRV_EXC_NONE)
      begin
         exc_trans_out <= trans_id_in;
         exc_proto_out <= `MRV_PROTO_ID;
         exc_len_out <= `MRV_EXC_LEN;
         exc_unit_out <= unit_id_in;
         exc_func_out <= func_in | `MRV_EXC_FLAG;
         exc_code_out <= next_code;
      end
   end

   // Analog reply; value holds until the next accepted request
   always @(posedge clk_in)
   begin
      if (rst_in)
      begin
         zero_fill_out <= 1'b0;
         value_out <= 16'h0000;
      end
      else if (ce_in && req_valid_in)
      begin
         if (next_code != `MRV_EXC_NONE)
         begin
            zero_fill_out <= 1'b0;
         end
         else
         begin
            // A first read of a group cannot have data yet
            zero_fill_out <= analog &&
               (init_rd || !threshold_in);
            value_out <= (analog && threshold_in && !init_rd) ?
               panel_value_in : 16'h0000;
         end
      end
   end

endmodule // mrv_request_validator

// ### mrv_props.sv
/* Checker for the request validator, watching its ports only.
   Assumes a bind from the bench top file and a single clock domain. */
`timescale 1ns/1ns
module mrv_props
(
   input wire clk_in, // Clock
   input wire rst_in, // Reset
   input wire ce_in, // Enable
   input wire req_valid_in, // Request
   input wire [15:0] trans_id_in, // Transaction
   input wire [15:0] proto_id_in, // Protocol
   input wire [7:0] unit_id_in, // Unit
   input wire [7:0] func_in, // Function
   input wire [7:0] gw_unit_in, // Gateway unit
   input wire unit_cfg_in, // Configured
   input wire panel_online_in, // Online
   input wire fwd_valid_out, // Forward
   input wire exc_valid_out, // Exception
   input wire [15:0] exc_trans_out, // Echo id
   input wire [15:0] exc_proto_out, // Protocol
   input wire [15:0] exc_len_out, // Length
   input wire [7:0] exc_unit_out, // Echo unit
   input wire [7:0] exc_func_out, // Function
   input wire [7:0] exc_code_out, // Code
   input wire zero_fill_out, // Zeros
   input wire [15:0] value_out // Value
);
wire take = req_valid_in & ce_in;
wire pnl = take && proto_id_in == 16'h0000 && unit_id_in != gw_unit_in;
// ----------------------------------------
// Reply checks
// ----------------------------------------
default clocking cb @(posedge clk_in);
endclocking
default disable iff (rst_in);
chk_exc_flag: assert property (exc_valid_out |-> exc_func_out[7])
   else $error("exception without top bit");
chk_code_set: assert property (exc_valid_out |-> exc_code_out inside {8'h01, 8'h02, 8'h03, 8'h0A, 8'h0B})
   else $error("unknown exception code");
chk_proto_code: assert property (take && proto_id_in != 16'h0000 |=> exc_valid_out && exc_code_out == 8'h01)
   else $error("bad protocol not refused");
chk_cfg_code: assert property (pnl && !unit_cfg_in |=> exc_valid_out && exc_code_out == 8'h0A)
   else $error("unconfigured unit not refused");
chk_offline_code: assert property (pnl && unit_cfg_in && func_in == 8'h04 && !panel_online_in
   |=> exc_valid_out && exc_code_out == 8'h0B)
   else $error("offline panel not refused");
chk_echo_ids: assert property (take |=> !exc_valid_out || (exc_trans_out == $past(trans_id_in)
   && exc_unit_out == $past(unit_id_in) && exc_func_out == ($past(func_in) | 8'h80)))
   else $error("reply does not echo request");
chk_frame_len: assert property (exc_valid_out |-> exc_len_out == 16'h0003 && exc_proto_out == 16'h0000)
   else $error("bad reply length");
chk_one_answer: assert property (take |=> fwd_valid_out != exc_valid_out)
   else $error("not exactly one answer");
chk_no_spont: assert property (!take |=> !fwd_valid_out && !exc_valid_out)
   else $error("answer without request");
chk_zero_value: assert property (zero_fill_out |-> value_out == 16'h0000)
   else $error("zero fill with value");
cov_exc: cover property (exc_valid_out);
cov_fwd: cover property (fwd_valid_out);
cov_zero: cover property ($rose(zero_fill_out));
endmodule // mrv_props

// ### mrv_client.sv
/* Modbus client model: one request at a time, fields released after the pulse.
   Assumes the bench calls send and the validator answers on its pulses. */
`timescale 1ns/1ns
module mrv_client
(
   input wire clk_in, // Clock
   input wire fwd_in, // Forward pulse
   input wire exc_in, // Exception pulse
   output reg req_out, // Request pulse
   output reg [15:0] trans_out, // Transaction
   output reg [15:0] proto_out, // Protocol
   output reg [7:0] unit_out, // Unit
   output reg [7:0] func_out, // Function
   output reg [15:0] start_out, // Start
   output reg [15:0] count_out // Count
);
initial
begin
   req_out = 1'b0;
   {trans_out, proto_out, unit_out, func_out, start_out, count_out} = 80'h0;
end
// ----------------------------------------
// Request and wait for the reply
// ----------------------------------------
task send(input [15:0] t, p, input [7:0] u, f, input [15:0] s, c, output integer lat);
   reg [79:0] h;
   begin
      h = {t, p, u, f, s, c};
      @(negedge clk_in);
      {trans_out, proto_out, unit_out, func_out, start_out, count_out} = h;
      req_out = 1'b1;
      @(negedge clk_in);
      req_out = 1'b0;
      // Released fields must not keep looking like the request
      {trans_out, proto_out, unit_out, func_out, start_out, count_out} = ~h;
      lat = 1;
      while (!(fwd_in || exc_in) && lat < 8)
      begin
         @(negedge clk_in);
         lat = lat + 1;
      end
   end
endtask
endmodule // mrv_client

// ### mrv_request_validator_tb_top.sv
/* Bench for the request validator: client model, panel levels and scenarios.
   Assumes a 25 MHz clock and a shortened refresh timeout. */
`timescale 1ns/1ns
`define CHK(a, e) begin samples_checked = samples_checked + 1; if ((a) !== (e)) \
   begin n_fail = n_fail + 1; $display("BAD %0t got %h want %h", $time, a, e); end end
module mrv_request_validator_tb_top;
localparam TMO = 50;
reg clk = 1'b0;
reg rst = 1'b1;
reg ce = 1'b1;
reg [7:0] env = 8'hFF;
reg [15:0] val = 16'h1234;
reg [15:0] tid = 16'h0100;
integer n_fail = 0;
integer samples_checked = 0;
integer lat;
wire req, fwd, exc, zf, rfr;
wire [15:0] tr, pr, st, ct, et, ep, el, vo;
wire [7:0] un, fc, eu, ef, ec;
always #20 clk = ~clk;
mrv_client u_mrv_client (.clk_in(clk), .fwd_in(fwd), .exc_in(exc), .req_out(req),
   .trans_out(tr), .proto_out(pr), .unit_out(un), .func_out(fc), .start_out(st), .count_out(ct));
mrv_request_validator #(.TIMEOUT_CYC(TMO)) u_mrv_request_validator (.clk_in(clk),
   .rst_in(rst), .ce_in(ce), .req_valid_in(req), .trans_id_in(tr), .proto_id_in(pr),
   .unit_id_in(un), .func_in(fc), .start_in(st), .count_in(ct), .write_ok_in(env[6]),
   .gw_unit_in(8'h01), .unit_cfg_in(env[0]), .panel_online_in(env[1]), .net_ok_in(env[2]),
   .func_ok_in(env[3]), .present_in(env[4]), .all_analog_in(env[5]), .threshold_in(env[7]),
   .panel_value_in(val), .fwd_valid_out(fwd), .exc_valid_out(exc), .exc_trans_out(et),
   .exc_proto_out(ep), .exc_len_out(el), .exc_unit_out(eu), .exc_func_out(ef),
   .exc_code_out(ec), .zero_fill_out(zf), .value_out(vo), .refresh_out(rfr));
task rq(input [15:0] p, input [7:0] u, f, input [15:0] s, c);
   begin
      tid = tid + 16'h0001;
      u_mrv_client.send(tid, p, u, f, s, c, lat);
   end
endtask
// ----------------------------------------
// Scenarios
// ----------------------------------------
// A code of zero means the request must be forwarded
task tcase(input [15:0] p, input [7:0] u, f, input [15:0] s, c, input [7:0] e, code);
   begin
      env = e;
      rq(p, u, f, s, c);
      `CHK(lat, 1)
      `CHK(fwd, code == 8'h00)
      `CHK(exc, code != 8'h00)
      if (code != 8'h00)
      begin
         `CHK(ec, code)
         `CHK(ef, f | 8'h80)
         `CHK(et, tid)
         `CHK(eu, u)
         `CHK(ep, 16'h0000)
         `CHK(el, 16'h0003)
      end
   end
endtask
task analog_refresh;
   begin
      env = 8'hFF;
      rq(16'h0000, 8'h02, 8'h04, 16'h7540, 16'h0004);
      `CHK(zf, 1'b1)
      rq(16'h0000, 8'h02, 8'h04, 16'h7540, 16'h0004);
      `CHK(zf, 1'b0)
      `CHK(vo, val)
      `CHK(rfr, 1'b1)
      repeat (TMO - 10) @(negedge clk);
      rq(16'h0000, 8'h02, 8'h04, 16'h7540, 16'h0004);
      `CHK(zf, 1'b0)
      repeat (TMO + 20) @(negedge clk);
      `CHK(rfr, 1'b0)
      rq(16'h0000, 8'h02, 8'h04, 16'h7540, 16'h0004);
      `CHK(zf, 1'b1)
      env = 8'h7F;
      rq(16'h0000, 8'h02, 8'h04, 16'h7540, 16'h0004);
      `CHK(zf, 1'b1)
      `CHK(vo, 16'h0000)
   end
endtask
// Enable low must freeze the refresh timer along with everything else
task ce_freeze;
   begin
      env = 8'hFF;
      rq(16'h0000, 8'h02, 8'h04, 16'h7550, 16'h0002);
      `CHK(zf, 1'b1)
      @(negedge clk);
      ce = 1'b0;
      repeat (TMO + 20) @(negedge clk);
      `CHK(rfr, 1'b1)
      `CHK(fwd, 1'b0)
      ce = 1'b1;
      rq(16'h0000, 8'h02, 8'h04, 16'h7550, 16'h0002);
      `CHK(zf, 1'b0)
      `CHK(vo, val)
   end
endtask
task test_done;
   begin
      $display("checks %0d fails %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   end
endtask
initial
begin
   repeat (16) @(negedge clk);
   rst = 1'b0;
   tcase(16'h0000, 8'h02, 8'h03, 16'h9C41, 16'h0064, 8'hFF, 8'h00);
   tcase(16'h0001, 8'h02, 8'h03, 16'h9C41, 16'h0001, 8'hFF, 8'h01);
   tcase(16'h0000, 8'h02, 8'h03, 16'h9C41, 16'h0001, 8'hFE, 8'h0A);
   tcase(16'h0000, 8'h02, 8'h05, 16'h9C41, 16'h0001, 8'hFF, 8'h01);
   tcase(16'h0000, 8'h01, 8'h06, 16'h9C41, 16'h0001, 8'hFF, 8'h01);
   tcase(16'h0000, 8'h02, 8'h03, 16'h9C41, 16'h0001, 8'hFD, 8'h0B);
   tcase(16'h0000, 8'h02, 8'h03, 16'h9C41, 16'h0001, 8'hFB, 8'h0B);
   tcase(16'h0000, 8'h02, 8'h03, 16'h9C41, 16'h0001, 8'hF7, 8'h01);
   tcase(16'h0000, 8'h02, 8'h03, 16'h9C41, 16'h0065, 8'hFF, 8'h03);
   tcase(16'h0000, 8'h02, 8'h03, 16'h0001, 16'h0001, 8'hFF, 8'h02);
   tcase(16'h0000, 8'h02, 8'h04, 16'h7531, 16'h0002, 8'hDF, 8'h02);
   tcase(16'h0000, 8'h02, 8'h04, 16'h7531, 16'h000B, 8'hFF, 8'h03);
   tcase(16'h0000, 8'h02, 8'h04, 16'h7531, 16'h000A, 8'hFF, 8'h00);
   tcase(16'h0000, 8'h02, 8'h03, 16'h9C41, 16'h0001, 8'hEF, 8'h02);
   tcase(16'h0000, 8'h02, 8'h06, 16'h9C41, 16'h0001, 8'hBF, 8'h03);
   tcase(16'h0000, 8'h02, 8'h10, 16'h9C41, 16'h0002, 8'hFF, 8'h00);
   analog_refresh;
   ce_freeze;
   test_done;
end
initial
begin
   #400000;
   n_fail = n_fail + 1;
   test_done;
end
endmodule // mrv_request_validator_tb_top
bind mrv_request_validator mrv_props u_mrv_props (.*);
